// *** rtl/pgr_regs.svh ***
/*
  Timing constants, counter width and synchroniser settings for the power-good reset and standby control block.
  Assumes a 100 MHz reference clock; included by bare name.
*/
`ifndef PGR_REGS_SVH
`define PGR_REGS_SVH

// Reference clock period in picoseconds
`define PGR_CLK_PERIOD_PS 10000
// Least low time of supply-ok before the response, in ns
`define PGR_LOW_MIN_NS 4000
// Least high time of supply-ok before it counts as asserted, in ns
`define PGR_HIGH_MIN_NS 625
// Least low time in cycles, rounded up
`define PGR_LOW_MIN_CYC ((`PGR_LOW_MIN_NS * 1000 + `PGR_CLK_PERIOD_PS - 1) / `PGR_CLK_PERIOD_PS)
// Least high time in cycles, rounded up
`define PGR_HIGH_MIN_CYC ((`PGR_HIGH_MIN_NS * 1000 + `PGR_CLK_PERIOD_PS - 1) / `PGR_CLK_PERIOD_PS)
// Filter counter width
`define PGR_CNT_W 10
// Synchroniser depth
`define PGR_SYNC_STAGES 2
// Reset value of synchronised inputs
`define PGR_SYNC_RST 1'b0

`endif

// *** rtl/pgr_pkg.sv ***
/*
  Types for the power-good reset and standby control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pgr_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    PGR_RESET = 5'h01,
    PGR_RUN   = 5'h02,
    PGR_PARK  = 5'h04,
    PGR_CLEAR = 5'h08,
    PGR_HOLD  = 5'h10
  } pgr_state_t;

endpackage

// *** rtl/pgr_sync.sv ***
/*
  Multi-stage level synchroniser for one asynchronous input.
  Assumes the input is a slowly changing level.
*/
`timescale 1ns/1ps
`include "pgr_regs.svh"

module pgr_sync (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic [`PGR_SYNC_STAGES-1:0] chain_r;

  // Shift chain; only the last stage is read outside
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chain_r <= {`PGR_SYNC_STAGES{`PGR_SYNC_RST}};
    end else begin
      chain_r <= {chain_r[`PGR_SYNC_STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_r[`PGR_SYNC_STAGES-1];

endmodule

// *** rtl/pgr_ctrl.sv ***
/*
  Power-good filter, park-and-reset sequencer and standby mode control.
  Assumes supply-ok, power-on-sense and standby inputs are asynchronous levels
  and that the park sequence is run elsewhere and reports its completion.
*/
`timescale 1ns/1ps
`include "pgr_regs.svh"

module pgr_ctrl
  import pgr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Supply monitor
  input wire logic supply_ok_in,
  input wire logic power_on_sense_in,
  // Host mode control
  input wire logic standby_ctrl_in,
  // Park handshake with the mirror driver
  input wire logic park_done_in,
  output logic park_req_out,
  // Controller status
  output logic ctrl_reset_out,
  output logic active_mode_out
);

  logic ok_s;
  logic pos_s;
  logic stby_s;
  logic [`PGR_CNT_W-1:0] low_cnt_r;
  logic [`PGR_CNT_W-1:0] high_cnt_r;
  logic [`PGR_CNT_W-1:0] low_cnt_nxt;
  logic [`PGR_CNT_W-1:0] high_cnt_nxt;
  pgr_state_t state_r;
  pgr_state_t state_nxt;
  logic park_req_r;
  logic ctrl_reset_r;
  logic active_r;

  // Synchronisers for all asynchronous inputs
  pgr_sync u_sync_ok (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(supply_ok_in),
    .sync_out(ok_s)
  );
  pgr_sync u_sync_pos (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(power_on_sense_in),
    .sync_out(pos_s)
  );
  pgr_sync u_sync_stby (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(standby_ctrl_in),
    .sync_out(stby_s)
  );

  // Saturating counters of continuous low and high time
  localparam logic [`PGR_CNT_W-1:0] LOW_LIM = `PGR_CNT_W'(`PGR_LOW_MIN_CYC);
  localparam logic [`PGR_CNT_W-1:0] HIGH_LIM = `PGR_CNT_W'(`PGR_HIGH_MIN_CYC);
  localparam logic [`PGR_CNT_W-1:0] CNT_ONE = `PGR_CNT_W'(1);
  localparam logic [`PGR_CNT_W-1:0] CNT_ZERO = `PGR_CNT_W'(0);

  wire low_full = (low_cnt_r >= LOW_LIM);
  wire high_full = (high_cnt_r >= HIGH_LIM);
  // Low pulse shorter than the limit never reaches low_full
  wire supply_lost = low_full;
  // Power-on sense low means supplies are already below minimum
  wire supply_dead = !pos_s;
  wire supply_good = high_full && pos_s;

  assign low_cnt_nxt = ok_s ? CNT_ZERO : (low_full ? low_cnt_r : low_cnt_r + CNT_ONE);
  assign high_cnt_nxt = !ok_s ? CNT_ZERO : (high_full ? high_cnt_r : high_cnt_r + CNT_ONE);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_r <= CNT_ZERO;
      high_cnt_r <= CNT_ZERO;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      high_cnt_r <= high_cnt_nxt;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PGR_RESET: begin
        if (supply_good) begin
          state_nxt = PGR_RUN;
        end
      end
      PGR_RUN: begin
        if (supply_dead) begin
          state_nxt = PGR_CLEAR;
        end else if (supply_lost) begin
          state_nxt = PGR_PARK;
        end
      end
      PGR_PARK: begin
        if (park_done_in || supply_dead) begin
          state_nxt = PGR_CLEAR;
        end
      end
      PGR_CLEAR: begin
        state_nxt = PGR_HOLD;
      end
      PGR_HOLD: begin
        if (supply_good) begin
          state_nxt = PGR_RUN;
        end
      end
      default: begin
        state_nxt = PGR_RESET;
      end
    endcase
  end

  // Registered outputs
  wire park_req_nxt = (state_nxt == PGR_PARK);
  wire ctrl_reset_nxt = (state_nxt != PGR_RUN) && (state_nxt != PGR_PARK);
  wire active_nxt = (state_nxt == PGR_RUN) && stby_s;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= PGR_RESET;
      park_req_r <= 1'b0;
      ctrl_reset_r <= 1'b1;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      park_req_r <= park_req_nxt;
      ctrl_reset_r <= ctrl_reset_nxt;
      active_r <= active_nxt;
    end
  end

  assign park_req_out = park_req_r;
  assign ctrl_reset_out = ctrl_reset_r;
  assign active_mode_out = active_r;

endmodule

// *** bench/pgr_ctrl_assertions.sv ***
/* Port timing checks for pgr_ctrl. Assumes one 100 MHz clock and the bind below. */
`timescale 1ns/1ps
module pgr_ctrl_assertions (
  // Watched ports
  input wire logic ref_clk_in, rst_n_in, supply_ok_in, power_on_sense_in, standby_ctrl_in,
  input wire logic park_done_in, park_req_out, ctrl_reset_out, active_mode_out
);
  int lo_r = 0;
  int hi_r = 0;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Run lengths of low supply and of good supply
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lo_r <= 0;
      hi_r <= 0;
    end else begin
      lo_r <= supply_ok_in ? 0 : (lo_r < 999 ? lo_r + 1 : lo_r);
      hi_r <= (supply_ok_in && power_on_sense_in) ? (hi_r < 999 ? hi_r + 1 : hi_r) : 0;
    end
  end
  // Running with a steady mode command
  sequence s_run;
    (!ctrl_reset_out && !park_req_out && $stable(standby_ctrl_in))[*4];
  endsequence
  a_park_late: assert property ($rose(park_req_out) |-> lo_r >= 400) else $error("park too early");
  a_park_due: assert property (lo_r == 410 && !ctrl_reset_out |-> park_req_out) else $error("no park");
  a_park_reset: assert property (park_req_out && park_done_in |=> !park_req_out && ctrl_reset_out)
    else $error("no reset after park");
  a_hold_low: assert property (lo_r > 3 && ctrl_reset_out |=> ctrl_reset_out) else $error("left reset");
  a_release_wait: assert property ($fell(ctrl_reset_out) |-> hi_r >= 63) else $error("early exit");
  a_release_due: assert property (hi_r == 75 |-> !ctrl_reset_out) else $error("late exit");
  a_mode_follow: assert property (s_run |-> active_mode_out == standby_ctrl_in) else $error("bad mode");
  a_mode_sync: assert property ($rose(active_mode_out) |-> $past(standby_ctrl_in, 3)) else $error("no sync");
endmodule

bind pgr_ctrl pgr_ctrl_assertions u_pgr_ctrl_assertions (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .supply_ok_in(supply_ok_in), .power_on_sense_in(power_on_sense_in), .standby_ctrl_in(standby_ctrl_in),
  .park_done_in(park_done_in), .park_req_out(park_req_out), .ctrl_reset_out(ctrl_reset_out),
  .active_mode_out(active_mode_out));

// *** bench/pgr_monitor_model.sv ***
/* Supply monitor model. Assumes the bench commands rail state and glitches. */
`timescale 1ns/1ps
module pgr_monitor_model #(parameter int WARN_CYC = 50000) (
  // Commands and monitor outputs
  input wire logic ref_clk_in, rails_ok_in, glitch_in,
  output logic supply_ok_out, power_on_sense_out
);
  int warn_r = 0;
  // Warning time left before rails fall
  always_ff @(posedge ref_clk_in) begin
    warn_r <= rails_ok_in ? WARN_CYC : (warn_r > 0 ? warn_r - 1 : 0);
  end
  assign supply_ok_out = rails_ok_in && !glitch_in;
  assign power_on_sense_out = warn_r != 0;
endmodule

// *** bench/test_power_good_reset_standby_control.sv ***
/* Bench for pgr_ctrl with a monitor model. Assumes a 100 MHz clock. */
`timescale 1ns/1ps
module test_power_good_reset_standby_control;
  logic clk = 0, rst_n = 0, rails = 0, glitch = 0, stby = 1, done = 0, m = 1;
  wire sok, pos, preq, crst, act;
  int fail_count = 0, total_checks = 0, n;
  pgr_monitor_model #(.WARN_CYC(50000)) u_pgr_monitor_model (.ref_clk_in(clk), .rails_ok_in(rails),
    .glitch_in(glitch), .supply_ok_out(sok), .power_on_sense_out(pos));
  pgr_ctrl u_pgr_ctrl (.ref_clk_in(clk), .rst_n_in(rst_n), .supply_ok_in(sok), .power_on_sense_in(pos),
    .standby_ctrl_in(stby), .park_done_in(done), .park_req_out(preq), .ctrl_reset_out(crst), .active_mode_out(act));
  task automatic cy(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock
  initial forever #5 clk = ~clk;
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    n = $urandom(32'hEECB8CF5);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk) rails <= 1;
    cy(60);
    chk(crst, 1);
    cy(20);
    chk(crst, 0);
    for (int i = 0; i < 8; i++) begin
      n = $urandom % 2;
      @(posedge clk) stby <= n[0];
      cy(1);
      chk(act, m);
      cy(4);
      chk(act, n[0]);
      m = n[0];
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) glitch <= 1;
      cy($urandom_range(1, 390));
      @(posedge clk) glitch <= 0;
      cy(10);
      chk(preq | crst, 0);
    end
    @(posedge clk) rails <= 0;
    cy(395);
    chk(preq, 0);
    for (n = 0; n < 20 && !preq; n++) cy(1);
    chk(preq, 1);
    cy($urandom_range(1, 50));
    @(posedge clk) done <= 1;
    @(posedge clk) done <= 0;
    cy(1);
    chk(crst, 1);
    cy(300);
    chk(crst, 1);
    @(posedge clk) rails <= 1;
    cy(80);
    chk(crst, 0);
    end_of_test();
  end
endmodule
